// [idrd_defines.svh]
// register offsets, field positions and reset values of the i/o window
`ifndef IDRD_DEFINES_SVH
`define IDRD_DEFINES_SVH

// ****************************************
// window geometry
// ****************************************
`define IDRD_WINDOW_SIZE 5'h10
`define IDRD_BASE_DEFAULT 10'h220
`define IDRD_SWITCH_DEFAULT 6'h1D

// ****************************************
// offsets
// ****************************************
`define IDRD_OFF_RSVD_ZERO 4'h0
`define IDRD_OFF_TIMER_ONE 4'h1
`define IDRD_OFF_TIMER_TWO 4'h2
`define IDRD_OFF_TIMER_CTRL 4'h3
`define IDRD_OFF_CONV_LOW 4'h4
`define IDRD_OFF_CONV_HIGH 4'h5
`define IDRD_OFF_INPUT_LOW 4'h6
`define IDRD_OFF_INPUT_HIGH 4'h7
`define IDRD_OFF_IRQ_CLEAR 4'h8
`define IDRD_OFF_GAIN 4'h9
`define IDRD_OFF_CHANNEL 4'hA
`define IDRD_OFF_MODE 4'hB
`define IDRD_OFF_TRIGGER 4'hC
`define IDRD_OFF_OUTPUT_LOW 4'hD
`define IDRD_OFF_OUTPUT_HIGH 4'hE
`define IDRD_OFF_RSVD_FIFTEEN 4'hF

// ****************************************
// fields and reset values
// ****************************************
`define IDRD_BUSY_BIT 4
`define IDRD_HIGH_NIBBLE_MSB 3
`define IDRD_RESET_BYTE 8'h00
`define IDRD_RESET_CODE 12'h000
`define IDRD_RESET_WORD 16'h0000

`endif

// [idrd_pkg.sv]
// types shared by the register decode block
package idrd_pkg;

  // one sample of the isa i/o bus
  typedef struct packed {
    logic [9:0] addr;
    logic aen;
    logic ior_n;
    logic iow_n;
    logic [7:0] wdata;
  } idrd_isa_type;

  // converter settings written by software
  typedef struct packed {
    logic [1:0] gain;
    logic [3:0] channel;
    logic [7:0] mode;
  } idrd_adc_cfg_type;

  typedef enum logic [0:0] {
    IDRD_IDLE = 1'b0,
    IDRD_CONV = 1'b1
  } idrd_conv_type;

endpackage

// [idrd_addr_match.sv]
// base address compare against the switch bank
`timescale 1ns/10ps
`include "idrd_defines.svh"
module idrd_addr_match
  import idrd_pkg::*;
(
  // bus side
  input wire logic [9:0] addr,
  input wire logic aen,
  // switches, 1 = switch in on position
  input wire logic [5:0] base_address_switch,
  // decode result
  output logic hit,
  output logic [3:0] offset
);

  wire [5:0] bit_eq;

  // on reads as 0, off as 1 [RL3]
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_cmp
      assign bit_eq[g] = (addr[g+4] == ~base_address_switch[g]); // [RL3]
    end
  endgenerate

  // sixteen-byte window, dma cycles (aen high) never match [RL1] [RL2]
  assign hit = (&bit_eq) & ~aen; // [RL1]
  assign offset = addr[3:0];

endmodule

// [idrd_dac_latch.sv]
// double-buffered output converter code latch
`timescale 1ns/10ps
`include "idrd_defines.svh"
module idrd_dac_latch
  import idrd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // write strobes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  // converter side
  output logic [11:0] dac_code
);

  logic [7:0] low_ff;
  logic [11:0] code_ff;
  wire [7:0] nxt_low;
  wire [11:0] nxt_code;

  // low byte waits in the buffer until the high nibble arrives [RL8]
  assign nxt_low = wr_low ? wdata : low_ff;
  // high write applies all twelve bits at once [RL9]
  assign nxt_code = wr_high ?
    {wdata[`IDRD_HIGH_NIBBLE_MSB:0], low_ff} : code_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      low_ff <= `IDRD_RESET_BYTE;
      code_ff <= `IDRD_RESET_CODE;
    end else begin
      low_ff <= nxt_low;
      code_ff <= nxt_code;
    end
  end

  assign dac_code = code_ff;

  property p_dac_hold;
    @(posedge clk_sys) disable iff (reset)
    !wr_high |=> $stable(code_ff);
  endproperty
  a_dac_hold: assert property (p_dac_hold) // [RL9]
    else $error("converter code moved without a high write");

endmodule

// [idrd_register_decode.sv]
// isa i/o window decode for the data-acquisition card
// Function
// [RL1] Sixteen consecutive i/o addresses from the base answer, no others.
// [RL2] The factory switch setting places the window at 0x220.
// [RL3] Address bits 9..4 match six switches, off as 1 and on as 0.
// [RL4] Offset 0 reserved, 1 and 2 timer data, 3 write-only timer control.
// [RL5] Offset 4 reads result bits 7..0, offset 5 bits 11..8 in bits 3..0.
// [RL6] Offset 5 reads the busy flag in bit 4 and zero in bits 7..5.
// [RL7] Busy is 1 during a conversion and 0 once the result is readable.
// [RL8] Writes to 4 and 5 take code bits 7..0 and 11..8, data 7..4 ignored.
// [RL9] The output code is double buffered and moves only on the high write.
// [RL10] Software writes the low byte before the high nibble.
// [RL11] Offsets 6 and 7 read digital inputs, 0xD and 0xE latch outputs.
// [RL12] Writes to 8..0xC are irq clear, gain, channel, mode and trigger.
// [RL13] Any write to offset 8 clears the conversion-complete status; here a completion in the same cycle wins and the status stays set.
// [RL14] Any write to offset 0xC starts one conversion.
// [RL15] Reserved writes are ignored and reserved reads leave the bus undriven.
`timescale 1ns/10ps
`include "idrd_defines.svh"
module idrd_register_decode
  import idrd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // isa bus
  input wire idrd_isa_type isa,
  output logic [7:0] data_out,
  output logic data_oe,
  // base address switches, 1 = on
  input wire logic [5:0] base_address_switch,
  // timer ports
  output logic [1:0] timer_port,
  output logic timer_rd,
  output logic timer_wr,
  output logic [7:0] timer_wdata,
  input wire logic [7:0] timer_rdata,
  // input converter
  input wire logic pacer_trigger,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  output logic adc_start,
  output idrd_adc_cfg_type adc_cfg,
  output logic conv_done_status,
  // output converter
  output logic [11:0] dac_code,
  // digital ports
  input wire logic [15:0] digital_input_port,
  output logic [15:0] digital_output_port
);

  // ****************************************
  // address decode
  // ****************************************
  logic hit;
  logic [3:0] offset;

  idrd_addr_match u_match (
    .addr(isa.addr),
    .aen(isa.aen),
    .base_address_switch(base_address_switch),
    .hit(hit),
    .offset(offset)
  );

  // ****************************************
  // strobe shaping
  // ****************************************
  // one write pulse per iow low phase; a long strobe must not retrigger
  logic iow_n_q_ff;
  wire wr_pulse;
  wire rd_active;

  assign wr_pulse = hit & ~isa.iow_n & iow_n_q_ff; // [RL1]
  assign rd_active = hit & ~isa.ior_n; // [RL1]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      iow_n_q_ff <= 1'b1;
    end else begin
      iow_n_q_ff <= isa.iow_n;
    end
  end

  // per-offset write strobes [RL4] [RL12]
  wire wr_timer;
  wire wr_dac_low;
  wire wr_dac_high;
  wire wr_irq_clear;
  wire wr_gain;
  wire wr_channel;
  wire wr_mode;
  wire wr_trigger;
  wire wr_out_low;
  wire wr_out_high;

  // offset 0 and 0xF decode to nothing on write [RL15]
  assign wr_timer = wr_pulse & (offset == `IDRD_OFF_TIMER_ONE
    || offset == `IDRD_OFF_TIMER_TWO
    || offset == `IDRD_OFF_TIMER_CTRL); // [RL4]
  assign wr_dac_low = wr_pulse & (offset == `IDRD_OFF_CONV_LOW); // [RL8]
  assign wr_dac_high = wr_pulse & (offset == `IDRD_OFF_CONV_HIGH); // [RL8]
  assign wr_irq_clear = wr_pulse & (offset == `IDRD_OFF_IRQ_CLEAR); // [RL12]
  assign wr_gain = wr_pulse & (offset == `IDRD_OFF_GAIN); // [RL12]
  assign wr_channel = wr_pulse & (offset == `IDRD_OFF_CHANNEL); // [RL12]
  assign wr_mode = wr_pulse & (offset == `IDRD_OFF_MODE); // [RL12]
  assign wr_trigger = wr_pulse & (offset == `IDRD_OFF_TRIGGER); // [RL12]
  assign wr_out_low = wr_pulse & (offset == `IDRD_OFF_OUTPUT_LOW); // [RL11]
  assign wr_out_high = wr_pulse & (offset == `IDRD_OFF_OUTPUT_HIGH); // [RL11]

  // ****************************************
  // timer pass-through
  // ****************************************
  logic timer_wr_ff;
  logic [1:0] timer_port_ff;
  logic [7:0] timer_wdata_ff;
  wire rd_timer;

  // counter control (offset 3) is write only [RL4]
  assign rd_timer = rd_active & (offset == `IDRD_OFF_TIMER_ONE
    || offset == `IDRD_OFF_TIMER_TWO); // [RL4]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      timer_wr_ff <= 1'b0;
      timer_port_ff <= 2'h0;
      timer_wdata_ff <= `IDRD_RESET_BYTE;
    end else begin
      timer_wr_ff <= wr_timer;
      if (wr_timer) begin
        timer_port_ff <= offset[1:0];
        timer_wdata_ff <= isa.wdata;
      end
    end
  end

  // read port follows the live address, write port the captured one
  assign timer_rd = rd_timer;
  assign timer_port = rd_timer ? offset[1:0] : timer_port_ff;
  assign timer_wr = timer_wr_ff;
  assign timer_wdata = timer_wdata_ff;

  // ****************************************
  // conversion control
  // ****************************************
  idrd_conv_type conv_ff;
  idrd_conv_type nxt_conv;
  logic [11:0] result_ff;
  logic start_ff;
  logic done_status_ff;
  wire start_req;

  assign start_req = wr_trigger | pacer_trigger; // [RL14]

  // a new start in the finishing cycle keeps busy set
  always_comb begin
    nxt_conv = conv_ff;
    case (conv_ff)
      IDRD_IDLE: begin
        if (start_req) begin
          nxt_conv = IDRD_CONV; // [RL7]
        end
      end
      IDRD_CONV: begin
        if (adc_done && !start_req) begin
          nxt_conv = IDRD_IDLE; // [RL7]
        end
      end
      default: begin
        nxt_conv = IDRD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      conv_ff <= IDRD_IDLE;
      result_ff <= `IDRD_RESET_CODE;
      start_ff <= 1'b0;
    end else begin
      conv_ff <= nxt_conv;
      start_ff <= start_req; // [RL14]
      // result captured on completion, the edge busy falls unless a new start comes with it [RL7]
      if (adc_done && conv_ff == IDRD_CONV) begin
        result_ff <= adc_result;
      end
    end
  end

  // completion sets, offset 8 write clears; set wins a tie [RL13]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      done_status_ff <= 1'b0;
    end else if (adc_done && conv_ff == IDRD_CONV) begin
      done_status_ff <= 1'b1;
    end else if (wr_irq_clear) begin
      done_status_ff <= 1'b0; // [RL13]
    end
  end

  assign adc_start = start_ff;
  assign conv_done_status = done_status_ff;

  // ****************************************
  // settings and digital outputs
  // ****************************************
  idrd_adc_cfg_type cfg_ff;
  logic [15:0] dout_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_ff <= '0;
      dout_ff <= `IDRD_RESET_WORD;
    end else begin
      if (wr_gain) begin
        cfg_ff.gain <= isa.wdata[1:0]; // [RL12]
      end
      if (wr_channel) begin
        cfg_ff.channel <= isa.wdata[3:0]; // [RL12]
      end
      if (wr_mode) begin
        cfg_ff.mode <= isa.wdata; // [RL12]
      end
      if (wr_out_low) begin
        dout_ff[7:0] <= isa.wdata; // [RL11]
      end
      if (wr_out_high) begin
        dout_ff[15:8] <= isa.wdata; // [RL11]
      end
    end
  end

  assign adc_cfg = cfg_ff;
  assign digital_output_port = dout_ff;

  // relies on software writing the low byte first [RL10]
  idrd_dac_latch u_dac (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_low(wr_dac_low),
    .wr_high(wr_dac_high),
    .wdata(isa.wdata),
    .dac_code(dac_code)
  );

  // ****************************************
  // read path
  // ****************************************
  wire busy;
  wire readable;
  logic [7:0] rd_mux;
  logic [7:0] rdata_ff;

  assign busy = (conv_ff == IDRD_CONV); // [RL7]

  // reserved reads leave the bus to other cards [RL15]
  assign readable = rd_timer
    | (offset == `IDRD_OFF_CONV_LOW)
    | (offset == `IDRD_OFF_CONV_HIGH)
    | (offset == `IDRD_OFF_INPUT_LOW)
    | (offset == `IDRD_OFF_INPUT_HIGH);

  always_comb begin
    rd_mux = `IDRD_RESET_BYTE;
    case (offset)
      `IDRD_OFF_TIMER_ONE, `IDRD_OFF_TIMER_TWO: begin
        rd_mux = timer_rdata; // [RL4]
      end
      `IDRD_OFF_CONV_LOW: begin
        rd_mux = result_ff[7:0]; // [RL5]
      end
      `IDRD_OFF_CONV_HIGH: begin
        rd_mux = {3'h0, busy, result_ff[11:8]}; // [RL5] [RL6]
      end
      `IDRD_OFF_INPUT_LOW: begin
        rd_mux = digital_input_port[7:0]; // [RL11]
      end
      `IDRD_OFF_INPUT_HIGH: begin
        rd_mux = digital_input_port[15:8]; // [RL11]
      end
      default: begin
        rd_mux = `IDRD_RESET_BYTE;
      end
    endcase
  end

  // read data registered; one cycle of ior low before it is valid
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_ff <= `IDRD_RESET_BYTE;
    end else begin
      rdata_ff <= rd_mux;
    end
  end

  assign data_out = rdata_ff;
  assign data_oe = rd_active & readable; // [RL15]

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_window;
    (isa.addr[9:4] != ~base_address_switch) |-> !data_oe && !wr_pulse;
  endproperty
  a_window: assert property (p_window) // [RL1]
    else $error("access outside the window was answered");
  property p_default_base;
    (base_address_switch == `IDRD_SWITCH_DEFAULT && !isa.aen
      && isa.addr[9:4] == `IDRD_BASE_DEFAULT >> 4) |-> hit;
  endproperty
  a_default_base: assert property (p_default_base) // [RL2]
    else $error("factory switch setting missed 0x220");
  property p_switch_sense;
    (hit) |-> (isa.addr[9:4] ^ base_address_switch) == 6'h3F;
  endproperty
  a_switch_sense: assert property (p_switch_sense) // [RL3]
    else $error("switch polarity wrong");
  property p_timer_write;
    wr_timer |=> timer_wr && timer_wdata == $past(isa.wdata);
  endproperty
  a_timer_write: assert property (p_timer_write) // [RL4]
    else $error("timer write lost");
  property p_high_read;
    (rd_active && offset == `IDRD_OFF_CONV_HIGH) ##1
      (rd_active && offset == `IDRD_OFF_CONV_HIGH) |->
      data_out[7:5] == 3'h0 && data_out[4] == $past(busy)
      && data_out[3:0] == $past(result_ff[11:8]);
  endproperty
  a_high_read: assert property (p_high_read) // [RL6]
    else $error("offset 5 read format wrong");
  property p_busy_clear;
    (busy && adc_done && !start_req) |=> !busy ##0
      result_ff == $past(adc_result);
  endproperty
  a_busy_clear: assert property (p_busy_clear) // [RL7]
    else $error("busy stuck after completion");
  property p_dac_pair;
    wr_dac_low ##1 (!wr_dac_low)[*3] ##0 wr_dac_high |=>
      dac_code == {$past(isa.wdata[3:0]), $past(isa.wdata, 4)};
  endproperty
  a_dac_pair: assert property (p_dac_pair) // [RL9]
    else $error("twelve-bit code not applied together");
  property p_trigger;
    wr_trigger |=> adc_start && busy;
  endproperty
  a_trigger: assert property (p_trigger) // [RL14]
    else $error("software trigger did not start a conversion");
  property p_irq_clear;
    (wr_irq_clear && !(adc_done && busy)) |=> !conv_done_status;
  endproperty
  a_irq_clear: assert property (p_irq_clear) // [RL13]
    else $error("status not cleared by offset 8 write");
  property p_rsvd_read;
    (offset == `IDRD_OFF_RSVD_ZERO || offset >= `IDRD_OFF_IRQ_CLEAR)
      |-> !data_oe;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) // [RL15]
    else $error("reserved read drove the bus");

  c_soft_conv: cover property (wr_trigger ##[1:100] (busy && adc_done));
  c_dac_update: cover property (wr_dac_low ##[1:20] wr_dac_high);
  c_status_read: cover property (rd_active
    && offset == `IDRD_OFF_CONV_HIGH && busy);

endmodule

// [idrd_host_model.sv]
// host bus master model driving isa i/o read and write cycles
`timescale 1ns/10ps
module idrd_host_model
  import idrd_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // bus
  output idrd_isa_type isa,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    isa = '{10'h000, 1'b0, 1'b1, 1'b1, 8'h00};
  end

  // strobe returns high for a cycle, so each call is one write
  task automatic io_wr(input logic [9:0] a, input logic dma,
                       input logic [7:0] d);
    @(posedge clk_sys);
    isa.addr <= a;
    isa.aen <= dma;
    isa.wdata <= d;
    isa.iow_n <= 1'b0;
    @(posedge clk_sys);
    isa.iow_n <= 1'b1;
    isa.aen <= 1'b0;
    // released data must not keep showing the written byte
    isa.wdata <= ~d;
    @(posedge clk_sys);
  endtask

  task automatic io_rd(input logic [9:0] a, input logic dma,
                       output logic [7:0] d, output logic oe);
    @(posedge clk_sys);
    isa.addr <= a;
    isa.aen <= dma;
    isa.ior_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    d = data_out;
    oe = data_oe;
    @(posedge clk_sys);
    isa.ior_n <= 1'b1;
    isa.aen <= 1'b0;
  endtask

  // upper data bits carry junk on purpose
  task automatic dac_set(input logic [9:0] base, input logic [11:0] code);
    io_wr(base + 10'h004, 1'b0, code[7:0]);
    io_wr(base + 10'h005, 1'b0, {code[7:4], code[11:8]});
  endtask
endmodule

// [isa_daq_register_decode_tb_top.sv]
// self-checking bench for the isa i/o window decode
`timescale 1ns/10ps
`include "idrd_defines.svh"
module isa_daq_register_decode_tb_top;
  import idrd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [5:0] sw = `IDRD_SWITCH_DEFAULT;
  logic [7:0] timer_rdata = 8'h00;
  logic pacer_trigger = 1'b0;
  logic adc_done = 1'b0;
  logic [11:0] adc_result = 12'h000;
  logic [15:0] din = 16'h0000;
  idrd_isa_type isa;
  logic [7:0] data_out, timer_wdata, rd, b, twd;
  logic data_oe, timer_rd, timer_wr, adc_start, conv_done_status, oe;
  logic [1:0] timer_port, twp, trp;
  idrd_adc_cfg_type adc_cfg;
  logic [11:0] dac_code, res, ed;
  logic [15:0] digital_output_port;
  logic [9:0] base = `IDRD_BASE_DEFAULT;
  integer seed = 99;
  int miscompares = 0;
  int total_checks = 0;
  int starts = 0;
  int twr = 0;
  int n;
  int m;
  int k;
  int trd = 0;

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (adc_start === 1'b1) starts <= starts + 1;
    if (timer_wr === 1'b1) begin
      twr <= twr + 1;
      twd <= timer_wdata;
      twp <= timer_port;
    end
    if (timer_rd === 1'b1) begin
      trd <= trd + 1;
      trp <= timer_port;
    end
  end

  idrd_register_decode u_dut (.clk_sys(clk_sys), .reset(reset), .isa(isa),
    .data_out(data_out), .data_oe(data_oe), .base_address_switch(sw),
    .timer_port(timer_port), .timer_rd(timer_rd), .timer_wr(timer_wr),
    .timer_wdata(timer_wdata), .timer_rdata(timer_rdata),
    .pacer_trigger(pacer_trigger), .adc_done(adc_done),
    .adc_result(adc_result), .adc_start(adc_start), .adc_cfg(adc_cfg),
    .conv_done_status(conv_done_status), .dac_code(dac_code),
    .digital_input_port(din), .digital_output_port(digital_output_port));
  idrd_host_model u_host (.clk_sys(clk_sys), .isa(isa),
    .data_out(data_out), .data_oe(data_oe));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] off, input logic [7:0] d);
    u_host.io_wr(base + {6'h00, off}, 1'b0, d);
    settle();
  endtask
  task automatic rdv(input logic [3:0] off);
    u_host.io_rd(base + {6'h00, off}, 1'b0, rd, oe);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [7:0] status_byte(input logic bsy,
    input logic [11:0] r);
    return {3'h0, bsy, r[11:8]};
  endfunction
  function automatic logic [11:0] code_of(input logic [7:0] lo,
    input logic [7:0] hi);
    return {hi[3:0], lo};
  endfunction
  task automatic convert_end();
    res = 12'($random(seed));
    @(posedge clk_sys);
    adc_done <= 1'b1;
    adc_result <= res;
    @(posedge clk_sys);
    adc_done <= 1'b0;
    adc_result <= ~res;
    settle();
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    settle();
    check(dac_code, 0);
    check(digital_output_port, 0);
    check(adc_cfg, 0);
    done("reset");
    // default window, outside block and dma cycles
    b = 8'($random(seed));
    wr(`IDRD_OFF_OUTPUT_LOW, b);
    check(digital_output_port[7:0], b);
    wr(`IDRD_OFF_OUTPUT_HIGH, ~b);
    check(digital_output_port, {~b, b});
    u_host.io_wr(base + 10'h01D, 1'b0, 8'h5A);
    u_host.io_wr(base + 10'h00D, 1'b1, 8'h5A);
    settle();
    check(digital_output_port, {~b, b});
    u_host.io_rd(base - 10'h001, 1'b0, rd, oe);
    check(oe, 0);
    @(posedge clk_sys);
    din <= 16'($random(seed));
    rdv(`IDRD_OFF_INPUT_LOW);
    check({oe, rd}, {1'b1, din[7:0]});
    rdv(`IDRD_OFF_INPUT_HIGH);
    check({oe, rd}, {1'b1, din[15:8]});
    done("window");
    // switch settings, on compares as zero
    for (n = 0; n < 4; n++) begin
      @(posedge clk_sys);
      sw <= 6'($random(seed));
      @(posedge clk_sys);
      base = {~sw, 4'h0};
      b = 8'($random(seed));
      wr(`IDRD_OFF_OUTPUT_LOW, b);
      check(digital_output_port[7:0], b);
      u_host.io_wr(base ^ 10'h200, 1'b0, ~b);
      settle();
      check(digital_output_port[7:0], b);
    end
    done("switches");
    // reserved places
    ed = dac_code;
    for (n = 0; n < 16; n++) begin
      if (n == 0 || n == 6 || n == 7 || n == 15) begin
        wr(n[3:0], 8'hA5);
      end
    end
    check(dac_code, ed);
    check(digital_output_port[7:0], b);
    k = trd;
    for (n = 0; n < 16; n++) begin
      if (n == 0 || n == 3 || n >= 8) begin
        rdv(n[3:0]);
        check(oe, 0);
      end
    end
    check(4'(trd - k), 4'h0);
    done("reserved");
    // timer ports
    for (n = 1; n < 4; n++) begin
      @(posedge clk_sys);
      timer_rdata <= 8'($random(seed));
      m = twr;
      k = trd;
      if (n < 3) begin
        rdv(n[3:0]);
        check({oe, rd}, {1'b1, timer_rdata});
      end
      b = 8'($random(seed));
      wr(n[3:0], b);
      check({4'(twr - m), twp, twd}, {4'h1, n[1:0], b});
      check(4'(trd - k), (n < 3) ? 4'h2 : 4'h0);
      if (n < 3) begin
        check(trp, n[1:0]);
      end
    end
    done("timer");
    // converter settings
    b = 8'($random(seed));
    wr(`IDRD_OFF_GAIN, b);
    wr(`IDRD_OFF_CHANNEL, ~b);
    wr(`IDRD_OFF_MODE, b ^ 8'h3C);
    check(adc_cfg, {b[1:0], ~b[3:0], b ^ 8'h3C});
    done("config");
    // software and pacer start, busy, result, status clear
    n = starts;
    wr(`IDRD_OFF_TRIGGER, 8'($random(seed)));
    check(16'(starts - n), 1);
    rdv(`IDRD_OFF_CONV_HIGH);
    check(rd[7:4], 4'h1);
    convert_end();
    check(conv_done_status, 1);
    rdv(`IDRD_OFF_CONV_LOW);
    check(rd, res[7:0]);
    rdv(`IDRD_OFF_CONV_HIGH);
    check(rd, status_byte(1'b0, res));
    wr(`IDRD_OFF_IRQ_CLEAR, 8'($random(seed)));
    check(conv_done_status, 0);
    n = starts;
    u_host.io_wr(base + 10'h00C, 1'b0, 8'h00);
    wr(`IDRD_OFF_TRIGGER, 8'hFF);
    check(16'(starts - n), 2);
    convert_end();
    @(posedge clk_sys);
    pacer_trigger <= 1'b1;
    @(posedge clk_sys);
    pacer_trigger <= 1'b0;
    settle();
    rdv(`IDRD_OFF_CONV_HIGH);
    check(rd[4], 1);
    convert_end();
    done("conversion");
    // double-buffered output code
    for (n = 0; n < 5; n++) begin
      ed = 12'($random(seed));
      u_host.dac_set(base, ed);
      settle();
      check(dac_code, ed);
    end
    wr(`IDRD_OFF_CONV_LOW, ~ed[7:0]);
    check(dac_code, ed);
    b = 8'hF0 | {4'h0, ed[11:8] ^ 4'h5};
    wr(`IDRD_OFF_CONV_HIGH, b);
    check(dac_code, code_of(~ed[7:0], b));
    done("output code");
    // second reset in mid-run
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    settle();
    check(dac_code, 0);
    check(digital_output_port, 0);
    check({adc_cfg, conv_done_status}, 0);
    done("reset again");
    tally_and_finish();
  end
endmodule
